// ==== hdl/ptp_timestamp_packet_buffers.sv ====
// Purpose: PTP frame slot memories with hardware timestamps, send and receive.
// Assumes: Frame filter and transmit arbiter sit on clk; receive stream has no FCS.
// Notes: Stamps are the smooth counter's nanoseconds, little-endian at 0xFC.
`include "ptp_buf_params.svh"
module ptp_timestamp_packet_buffers (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Counter control and outputs
  input wire logic [`PTP_INC_WIDTH-1:0] rtc_increment,
  output logic [31:0] rtc_ns_wrap,
  // Configuration memory port
  input wire logic [16:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic cfg_err,
  // Transmit control and status
  input wire logic [7:0] tx_request,
  output logic [7:0] tx_waiting,
  output logic [2:0] tx_last_slot,
  output logic tx_done,
  // Transmit byte stream to the arbiter
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_last,
  input wire logic tx_ready,
  input wire logic tx_start,
  // Receive byte stream from the frame filter
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_last,
  output logic rx_ready,
  input wire logic rx_start,
  // Receive status
  output logic [3:0] rx_last_slot,
  output logic rx_done
);

  localparam int TX_BYTES = `PTP_TX_SLOTS * `PTP_SLOT_BYTES;
  localparam int RX_BYTES = `PTP_RX_SLOTS * `PTP_SLOT_BYTES;

  // Byte-wide slot memories
  logic [7:0] tx_mem [0:TX_BYTES-1];
  logic [7:0] rx_mem [0:RX_BYTES-1];

  // Counter
  logic [31:0] ns_smooth;

  ptp_rtc_counter u_rtc (
    .clk(clk),
    .rst_b(rst_b),
    .increment(rtc_increment),
    .ns_smooth(ns_smooth),
    .ns_wrap(rtc_ns_wrap)
  );

  // CRC-32 over one byte, reflected form
  function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] d);
    logic [31:0] c;
    c = crc ^ {24'h000000, d};
    for (int i = 0; i < 8; i++)
      c = c[0] ? ((c >> 1) ^ `PTP_CRC_POLY) : (c >> 1);
    return c;
  endfunction : crc_byte

  // Template frames in the first slots; last slot stays blank
  initial
  begin
    for (int a = 0; a < TX_BYTES; a++)
      tx_mem[a] = 8'h00;
    for (int s = 0; s < `PTP_TEMPLATE_SLOTS; s++)
    begin
      tx_mem[s*`PTP_SLOT_BYTES] = `PTP_TEMPLATE_LEN;
      tx_mem[s*`PTP_SLOT_BYTES + 8] = 8'h01;
      tx_mem[s*`PTP_SLOT_BYTES + 9] = 8'h80;
      tx_mem[s*`PTP_SLOT_BYTES + 10] = 8'hC2;
      tx_mem[s*`PTP_SLOT_BYTES + 13] = 8'h0E;
      tx_mem[s*`PTP_SLOT_BYTES + 20] = 8'(`PTP_ETHERTYPE >> 8);
      tx_mem[s*`PTP_SLOT_BYTES + 21] = 8'(`PTP_ETHERTYPE);
      tx_mem[s*`PTP_SLOT_BYTES + 22] = 8'(s);
    end
  end

  // Configuration address decode
  logic in_rx;
  logic in_tx;
  logic [11:0] rx_word;
  logic [10:0] tx_word;

  assign in_rx = (cfg_addr >= `PTP_RX_BASE) && (cfg_addr <= `PTP_RX_TOP);
  assign in_tx = (cfg_addr >= `PTP_TX_BASE) && (cfg_addr <= `PTP_TX_TOP);
  assign rx_word = {cfg_addr[11:2], 2'b00};
  assign tx_word = {cfg_addr[10:2], 2'b00};

  // Read data, one cycle after the strobe
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_rdata <= 32'h00000000;
      cfg_rvalid <= 1'b0;
    end
    else
    begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd && in_rx)
        cfg_rdata <= {rx_mem[rx_word + 12'd3], rx_mem[rx_word + 12'd2],
                      rx_mem[rx_word + 12'd1], rx_mem[rx_word]};
      else if (cfg_rd && in_tx)
        cfg_rdata <= {tx_mem[tx_word + 11'd3], tx_mem[tx_word + 11'd2],
                      tx_mem[tx_word + 11'd1], tx_mem[tx_word]};
      else if (cfg_rd)
        cfg_rdata <= 32'h00000000;
    end
  end

  // Error pulse for writes into receive memory or any unmapped access
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cfg_err <= 1'b0;
    else
      cfg_err <= (cfg_wr && !in_tx) || (cfg_rd && !in_rx && !in_tx);
  end

  // Transmit sequencer state
  ptp_buf_pkg::tx_state_t tx_state;
  logic [7:0] pending;
  logic [2:0] cur_slot;
  logic [7:0] cur_len;
  logic [7:0] byte_idx;
  logic [1:0] fcs_idx;
  logic [31:0] crc;
  logic [31:0] tx_stamp;
  logic [2:0] lowest;
  logic [7:0] send_len;
  logic [7:0] cur_byte;
  logic [31:0] fcs_val;
  logic tb_in_valid;
  logic tb_in_ready;
  logic [8:0] tb_in_data;
  logic [8:0] tb_out_data;

  // Lowest pending slot wins
  always_comb
  begin
    lowest = 3'h0;
    for (int i = `PTP_TX_SLOTS - 1; i >= 0; i--)
      if (pending[i])
        lowest = 3'(i);
  end

  // Frame bytes then zero padding up to the minimum size
  assign send_len = (cur_len < `PTP_MIN_FRAME) ? `PTP_MIN_FRAME : cur_len;
  assign cur_byte = (byte_idx < cur_len)
                  ? tx_mem[{cur_slot, byte_idx + `PTP_TX_DATA_OFS}] : 8'h00;
  assign fcs_val = ~crc;
  assign tb_in_valid = (tx_state == ptp_buf_pkg::TX_DATA)
                    || (tx_state == ptp_buf_pkg::TX_FCS);
  assign tb_in_data = (tx_state == ptp_buf_pkg::TX_FCS)
                    ? {fcs_idx == 2'd3, fcs_val[8*fcs_idx +: 8]}
                    : {1'b0, cur_byte};

  // Sequencer: pick, stream, drain, stamp
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_state <= ptp_buf_pkg::TX_IDLE;
      cur_slot <= 3'h0;
      cur_len <= 8'h00;
      byte_idx <= 8'h00;
      fcs_idx <= 2'h0;
      crc <= `PTP_CRC_INIT;
    end
    else
    begin
      case (tx_state)
        ptp_buf_pkg::TX_IDLE:
        begin
          if (pending != 8'h00)
          begin
            cur_slot <= lowest;
            cur_len <= (tx_mem[{lowest, 8'h00}] > `PTP_TX_MAX_LEN)
                     ? `PTP_TX_MAX_LEN : tx_mem[{lowest, 8'h00}];
            byte_idx <= 8'h00;
            fcs_idx <= 2'h0;
            crc <= `PTP_CRC_INIT;
            tx_state <= ptp_buf_pkg::TX_DATA;
          end
        end
        ptp_buf_pkg::TX_DATA:
        begin
          if (tb_in_ready)
          begin
            crc <= crc_byte(crc, cur_byte);
            byte_idx <= byte_idx + 8'h01;
            if (byte_idx == send_len - 8'h01)
              tx_state <= ptp_buf_pkg::TX_FCS;
          end
        end
        ptp_buf_pkg::TX_FCS:
        begin
          if (tb_in_ready)
          begin
            fcs_idx <= fcs_idx + 2'h1;
            if (fcs_idx == 2'h3)
              tx_state <= ptp_buf_pkg::TX_DRAIN;
          end
        end
        ptp_buf_pkg::TX_DRAIN:
        begin
          if (!tx_valid)
            tx_state <= ptp_buf_pkg::TX_STAMP;
        end
        ptp_buf_pkg::TX_STAMP:
          tx_state <= ptp_buf_pkg::TX_IDLE;
        default:
          tx_state <= ptp_buf_pkg::TX_IDLE;
      endcase
    end
  end

  // Stamp sampled as the arbiter reports the first symbol after the delimiter
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      tx_stamp <= 32'h00000000;
    else if (tx_start)
      tx_stamp <= ns_smooth;
  end

  // Pending requests; a new request beats the completion clear
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pending <= 8'h00;
    else if (tx_state == ptp_buf_pkg::TX_STAMP)
      pending <= (pending & ~(8'h01 << cur_slot)) | tx_request;
    else
      pending <= pending | tx_request;
  end

  assign tx_waiting = pending;

  // Done pulse and last sent slot, one cycle after the stamp write
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_done <= 1'b0;
      tx_last_slot <= 3'h0;
    end
    else
    begin
      tx_done <= (tx_state == ptp_buf_pkg::TX_STAMP);
      if (tx_state == ptp_buf_pkg::TX_STAMP)
        tx_last_slot <= cur_slot;
    end
  end

  // Outgoing byte buffer
  two_entry_buffer #(
    .WIDTH(9),
    .DEPTH(2)
  ) u_tx_buf (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(tb_in_valid),
    .in_data(tb_in_data),
    .in_ready(tb_in_ready),
    .out_valid(tx_valid),
    .out_data(tb_out_data),
    .out_ready(tx_ready)
  );

  assign tx_data = tb_out_data[7:0];
  assign tx_last = tb_out_data[8];

  // Transmit memory writes: config port and stamp
  always_ff @(posedge clk)
  begin
    if (cfg_wr && in_tx)
    begin
      tx_mem[tx_word] <= cfg_wdata[7:0];
      tx_mem[tx_word + 11'd1] <= cfg_wdata[15:8];
      tx_mem[tx_word + 11'd2] <= cfg_wdata[23:16];
      tx_mem[tx_word + 11'd3] <= cfg_wdata[31:24];
    end
    if (tx_state == ptp_buf_pkg::TX_STAMP)
    begin
      tx_mem[{cur_slot, `PTP_STAMP_OFS}] <= tx_stamp[7:0];
      tx_mem[{cur_slot, `PTP_STAMP_OFS + 8'h01}] <= tx_stamp[15:8];
      tx_mem[{cur_slot, `PTP_STAMP_OFS + 8'h02}] <= tx_stamp[23:16];
      tx_mem[{cur_slot, `PTP_STAMP_OFS + 8'h03}] <= tx_stamp[31:24];
    end
  end

  // Receive side
  logic rb_out_valid;
  logic rb_out_ready;
  logic [8:0] rb_out_data;
  logic [3:0] rx_slot;
  logic [7:0] rx_ptr;
  logic [31:0] rx_stamp;
  logic rx_stamping;
  logic rx_take;

  // Incoming byte buffer; the stamp cycle stalls it
  two_entry_buffer #(
    .WIDTH(9),
    .DEPTH(2)
  ) u_rx_buf (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(rx_valid),
    .in_data({rx_last, rx_data}),
    .in_ready(rx_ready),
    .out_valid(rb_out_valid),
    .out_data(rb_out_data),
    .out_ready(rb_out_ready)
  );

  assign rb_out_ready = !rx_stamping;
  assign rx_take = rb_out_valid && rb_out_ready;

  // Stamp sampled at the first symbol after the delimiter
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rx_stamp <= 32'h00000000;
    else if (rx_start)
      rx_stamp <= ns_smooth;
  end

  // Write pointer, slot rotation and stamp cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_slot <= 4'h0;
      rx_ptr <= 8'h00;
      rx_stamping <= 1'b0;
    end
    else if (rx_stamping)
    begin
      rx_stamping <= 1'b0;
      rx_slot <= rx_slot + 4'h1;
      rx_ptr <= 8'h00;
    end
    else if (rx_take)
    begin
      if (rb_out_data[8])
        rx_stamping <= 1'b1;
      else if (rx_ptr != `PTP_RX_MAX_LEN)
        rx_ptr <= rx_ptr + 8'h01;
    end
  end

  // Receive memory writes: frame bytes and stamp
  always_ff @(posedge clk)
  begin
    if (rx_take && !rx_stamping && rx_ptr != `PTP_RX_MAX_LEN)
      rx_mem[{rx_slot, rx_ptr}] <= rb_out_data[7:0];
    if (rx_stamping)
    begin
      rx_mem[{rx_slot, `PTP_STAMP_OFS}] <= rx_stamp[7:0];
      rx_mem[{rx_slot, `PTP_STAMP_OFS + 8'h01}] <= rx_stamp[15:8];
      rx_mem[{rx_slot, `PTP_STAMP_OFS + 8'h02}] <= rx_stamp[23:16];
      rx_mem[{rx_slot, `PTP_STAMP_OFS + 8'h03}] <= rx_stamp[31:24];
    end
  end

  // Receive pulse and last filled slot, one cycle after the stamp write
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_done <= 1'b0;
      rx_last_slot <= 4'h0;
    end
    else
    begin
      rx_done <= rx_stamping;
      if (rx_stamping)
        rx_last_slot <= rx_slot;
    end
  end

endmodule : ptp_timestamp_packet_buffers

// ==== hdl/ptp_buf_params.svh ====
// Purpose: Constants for the timestamp capture and frame slot buffers.
// Assumes: Byte addresses on the configuration port, little-endian words.
// Notes: Types live in ptp_buf_pkg; values live here.
//
// Notes on behaviour
// - Stamp every PTP frame sent or received, event or general alike.
// - Stamps come from the smooth controlled-frequency counter, never the offset one.
// - Stamp is taken at the first symbol after the frame start delimiter.
// - A second 32-bit nanosecond count runs its full range and wraps.
// - Transmit memory: config port reads and writes all; arbiter port reads frames.
// - Transmit memory holds eight 256-byte slots.
// - Slot byte 0 is length, bytes 1-7 reserved, frame at 8, 244 bytes max.
// - Stored frame omits padding and check sequence; transmit path adds both.
// - Transmit stamp sampled at start, written to bytes 0xFC-0xFF after end.
// - Transmit memory starts with templates in slots 0-6; slot 7 unused.
// - Any subset of slots may be requested; lowest pending slot goes first.
// - A readable per-slot waiting mask shows queued versus sent slots.
// - Done pulse after each frame, stamp stored and last-sent slot updated.
// - Receive memory: config port reads all, writes are refused.
// - The frame filter writes every received PTP frame into receive memory.
// - Receive memory holds sixteen 256-byte slots.
// - Frame stored from offset 0 without check sequence; beyond 252 bytes dropped.
// - Receive stamp sampled at start, written to bytes 0xFC-0xFF after end.
// - Slots fill upward from 0 after reset, wrapping after slot 15.
// - Receive pulse after each frame, stamp stored and last-filled slot updated.
// - All counter and stamp logic runs on the one reference clock.
// - Smooth counter resets to zero, adds the increment every cycle.
// - Receive memory appears at 0x10000 to 0x10FFC.
// - Transmit memory appears at 0x11000 to 0x117FC.
`ifndef PTP_BUF_PARAMS_SVH
`define PTP_BUF_PARAMS_SVH

`define PTP_RX_BASE 17'h10000
`define PTP_RX_TOP 17'h10FFC
`define PTP_TX_BASE 17'h11000
`define PTP_TX_TOP 17'h117FC
`define PTP_TX_SLOTS 8
`define PTP_RX_SLOTS 16
`define PTP_SLOT_BYTES 256
`define PTP_TX_DATA_OFS 8'h08
`define PTP_TX_MAX_LEN 8'hF4
`define PTP_RX_MAX_LEN 8'hFC
`define PTP_STAMP_OFS 8'hFC
`define PTP_MIN_FRAME 8'h3C
`define PTP_TEMPLATE_SLOTS 7
`define PTP_TEMPLATE_LEN 8'h2C
`define PTP_ETHERTYPE 16'h88F7
`define PTP_NS_PER_SEC 32'h3B9ACA00
`define PTP_CRC_POLY 32'hEDB88320
`define PTP_CRC_INIT 32'hFFFFFFFF
`define PTP_INC_WIDTH 26
`define PTP_SUBNS_WIDTH 20

`endif

// ==== hdl/ptp_buf_pkg.sv ====
// Purpose: Types shared by the timestamp buffer design.
// Assumes: Nothing beyond the params header.
// Notes: Constants are macros in ptp_buf_params.svh.
package ptp_buf_pkg;

  // Transmit sequencer states
  typedef enum logic [2:0] {
    TX_IDLE,
    TX_DATA,
    TX_FCS,
    TX_DRAIN,
    TX_STAMP
  } tx_state_t;

  typedef logic [7:0] byte_t;

endpackage : ptp_buf_pkg

// ==== hdl/two_entry_buffer.sv ====
// Purpose: Small valid/ready buffer so a stalled receiver loses no word.
// Assumes: Single clock, source and sink on clk.
// Notes: out_valid low means the buffer is empty.
module two_entry_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
  begin : g_bad_shape
    $error("two_entry_buffer: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] fill;
  logic push;
  logic pop;

  // Handshakes follow the fill level
  assign in_ready = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = store[rd_ptr];

  // Entry storage
  always_ff @(posedge clk)
  begin
    if (push)
      store[wr_ptr] <= in_data;
  end

  // Pointers and level
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + AW'(1);
      if (pop)
        rd_ptr <= rd_ptr + AW'(1);
      if (push && !pop)
        fill <= fill + (AW+1)'(1);
      else if (pop && !push)
        fill <= fill - (AW+1)'(1);
    end
  end

endmodule : two_entry_buffer

// ==== hdl/ptp_rtc_counter.sv ====
// Purpose: Smooth controlled-frequency nanosecond counter and free wrapping count.
// Assumes: Increment in 2^-20 ns units, programmed for the clk period.
// Notes: No offset stage; stamps need the smooth value only.
`include "ptp_buf_params.svh"
module ptp_rtc_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Increment per clock
  input wire logic [`PTP_INC_WIDTH-1:0] increment,
  // Counter values
  output logic [31:0] ns_smooth,
  output logic [31:0] ns_wrap
);

  localparam int FW = 32 + `PTP_SUBNS_WIDTH;

  logic [FW-1:0] smooth;
  logic [FW-1:0] wrap;
  logic [FW-1:0] next_smooth;

  assign next_smooth = smooth + FW'(increment);
  assign ns_smooth = smooth[FW-1:`PTP_SUBNS_WIDTH];
  assign ns_wrap = wrap[FW-1:`PTP_SUBNS_WIDTH];

  // Smooth count, rolls at one second
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      smooth <= '0;
    else if (next_smooth[FW-1:`PTP_SUBNS_WIDTH] >= `PTP_NS_PER_SEC)
      smooth <= next_smooth - {`PTP_NS_PER_SEC, `PTP_SUBNS_WIDTH'(0)};
    else
      smooth <= next_smooth;
  end

  // Full-range count, wraps at 2^32 ns
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      wrap <= '0;
    else
      wrap <= wrap + FW'(increment);
  end

endmodule : ptp_rtc_counter

// ==== testbench/ptp_buf_assertions.sv ====
// Purpose: Port-level checks for the timestamp slot buffers.
// Assumes: Clock clk, async active-low rst_b, bench keeps a 40 ns increment.
// Notes: Bound to the buffer top from the bench top file.
`include "ptp_buf_params.svh"
module ptp_buf_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Counter and configuration port
  input wire logic [`PTP_INC_WIDTH-1:0] rtc_increment,
  input wire logic [31:0] rtc_ns_wrap,
  input wire logic [16:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic cfg_rvalid,
  input wire logic cfg_err,
  // Transmit side
  input wire logic [7:0] tx_waiting,
  input wire logic [2:0] tx_last_slot,
  input wire logic tx_done,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic tx_ready,
  // Receive side
  input wire logic [3:0] rx_last_slot,
  input wire logic rx_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [3:0] rx_count;
  // Counts receive completions to know which slot is due next
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rx_count <= 4'h0;
    else if (rx_done)
      rx_count <= rx_count + 4'h1;
  end
  read_answer_a: assert property (cfg_rd |=> cfg_rvalid)
    else $error("read not answered next cycle");
  unmapped_read_a: assert property (cfg_rd && (cfg_addr < 17'h10000 || cfg_addr > 17'h117FC) |=> cfg_err)
    else $error("unmapped read not flagged");
  rx_write_refused_a: assert property (cfg_wr && cfg_addr >= 17'h10000 && cfg_addr <= 17'h10FFC |=> cfg_err)
    else $error("receive memory write not refused");
  tx_write_ok_a: assert property (cfg_wr && cfg_addr >= 17'h11000 && cfg_addr <= 17'h117FC |=> !cfg_err)
    else $error("transmit memory write flagged");
  rtc_step_a: assert property ($past(rst_b) && rtc_increment == 26'h2800000 && $past(rtc_increment) == 26'h2800000 |-> rtc_ns_wrap == $past(rtc_ns_wrap) + 32'h28)
    else $error("wrapping count step wrong");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("transmit byte changed while stalled");
  tx_done_pulse_a: assert property (tx_done |=> !tx_done)
    else $error("transmit done longer than a cycle");
  tx_clear_a: assert property (tx_done |-> !tx_waiting[tx_last_slot])
    else $error("sent slot still waiting");
  tx_order_a: assert property (tx_done |-> (tx_waiting & ((8'h01 << tx_last_slot) - 8'h01)) == 8'h00)
    else $error("lower slot left waiting");
  rx_slot_a: assert property (rx_done |-> rx_last_slot == rx_count ##1 !rx_done)
    else $error("receive slot out of sequence");
endmodule : ptp_buf_assertions

// ==== testbench/ptp_far_end_model.sv ====
// Purpose: Transmit arbiter sink and receive frame filter source.
// Assumes: Shares clk with the buffers; drives just after the rising edge.
// Notes: Sink stalls at random; source frames come from send_frame.
module ptp_far_end_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Transmit stream sink
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready,
  output logic tx_start,
  // Receive stream source
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_last,
  output logic rx_start,
  input wire logic rx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int tx_count;
  int tx_bytes;
  logic [7:0] tx_b14;
  // Idle receive lines
  initial
  begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_start = 1'b0;
  end
  // Arbiter: random stalls, start pulse after the first byte, byte counting
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_ready <= 1'b0;
      tx_start <= 1'b0;
      tx_count <= 0;
    end
    else
    begin
      tx_ready <= ($urandom % 4) != 0;
      tx_start <= tx_valid && tx_ready && tx_count == 0;
      if (tx_valid && tx_ready)
      begin
        if (tx_count == 14)
          tx_b14 <= tx_data;
        tx_count <= tx_last ? 0 : tx_count + 1;
        if (tx_last)
          tx_bytes <= tx_count + 1;
      end
    end
  end
  // Filter: one PTP frame, check sequence already stripped
  task send_frame(input int len, input logic [7:0] base);
    for (int i = 0; i < len; i++)
    begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= base + 8'(i);
      rx_last <= (i == len - 1);
      rx_start <= (i == 0);
      @(negedge clk);
      while (rx_ready !== 1'b1)
        @(negedge clk);
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_start <= 1'b0;
    rx_data <= ~rx_data;
  endtask : send_frame
endmodule : ptp_far_end_model

// ==== testbench/ptp_timestamp_packet_buffers_tb_top.sv ====
// Purpose: Self-checking bench for the timestamp slot buffers.
// Assumes: 25 MHz clock, increment of 40 ns per cycle.
// Notes: Random lengths and data from a fixed seed.
`include "ptp_buf_params.svh"
module ptp_timestamp_packet_buffers_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, cfg_wr, cfg_rd, cfg_rvalid, cfg_err, tx_done, tx_valid, tx_last;
  logic tx_ready, tx_start, rx_valid, rx_last, rx_ready, rx_start, rx_done, err_seen;
  logic [`PTP_INC_WIDTH-1:0] rtc_increment;
  logic [31:0] rtc_ns_wrap, cfg_wdata, cfg_rdata, d, ts, prev;
  logic [16:0] cfg_addr, a;
  logic [7:0] tx_request, tx_waiting, tx_data, rx_data, base;
  logic [2:0] tx_last_slot;
  logic [3:0] rx_last_slot;
  logic [2:0] tx_order [3] = '{3'h0, 3'h2, 3'h7};
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int len;
  ptp_timestamp_packet_buffers u_ptp_timestamp_packet_buffers (.clk(clk), .rst_b(rst_b),
    .rtc_increment(rtc_increment), .rtc_ns_wrap(rtc_ns_wrap), .cfg_addr(cfg_addr),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .cfg_err(cfg_err), .tx_request(tx_request),
    .tx_waiting(tx_waiting), .tx_last_slot(tx_last_slot), .tx_done(tx_done),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .tx_start(tx_start), .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last),
    .rx_ready(rx_ready), .rx_start(rx_start), .rx_last_slot(rx_last_slot), .rx_done(rx_done));
  ptp_far_end_model u_ptp_far_end_model (.clk(clk), .rst_b(rst_b), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .tx_start(tx_start),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last), .rx_start(rx_start),
    .rx_ready(rx_ready));
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fails++;
      end_sim();
    end
  end
  // Expected little-endian word of an incrementing byte pattern
  function automatic logic [31:0] exp_word(input logic [7:0] b, input int o);
    return {b + 8'(o + 3), b + 8'(o + 2), b + 8'(o + 1), b + 8'(o)};
  endfunction : exp_word
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task cfg_read(input logic [16:0] ad);
    @(posedge clk);
    cfg_addr <= ad;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1;
    d = cfg_rdata;
    err_seen = cfg_err;
  endtask : cfg_read
  task cfg_write(input logic [16:0] ad, input logic [31:0] wd);
    @(posedge clk);
    cfg_addr <= ad;
    cfg_wdata <= wd;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    #1;
    err_seen = cfg_err;
  endtask : cfg_write
  task wait_done(input bit is_tx);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (((is_tx ? tx_done : rx_done) !== 1'b1) && n < 3000);
    if (n >= 3000)
      chk("done wait", 32'h0, 32'h1);
  endtask : wait_done
  task do_reset;
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
  endtask : do_reset
  task end_sim;
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  // Main sequence
  initial
  begin
    void'($urandom(32'hF2BF3D29));
    {rst_b, cfg_wr, cfg_rd, cfg_addr, cfg_wdata, tx_request} = '0;
    rtc_increment = 26'h2800000;
    do_reset();
    #1;
    chk("waiting at reset", {24'h0, tx_waiting}, 32'h0);
    // Template lengths in slots 0-6, zero length in slot 7
    for (int s = 0; s < 8; s++)
    begin
      cfg_read(17'h11000 + 17'(s * 256));
      chk("template len", {24'h0, d[7:0]}, (s < 7) ? 32'h2C : 32'h0);
    end
    d = $urandom;
    ts = d;
    cfg_write(17'h11704, ts);
    chk("tx write err", {31'h0, err_seen}, 32'h0);
    cfg_read(17'h11704);
    chk("tx readback", d, ts);
    cfg_read(17'h11800);
    chk("unmapped err", {31'h0, err_seen}, 32'h1);
    chk("unmapped data", d, 32'h0);
    // Three slots requested together, sent lowest first
    @(posedge clk);
    tx_request <= 8'h85;
    #1 ts = rtc_ns_wrap;
    @(posedge clk);
    tx_request <= 8'h00;
    #1;
    chk("waiting mask", {24'h0, tx_waiting}, 32'h85);
    for (int k = 0; k < 3; k++)
    begin
      wait_done(1'b1);
      chk("tx slot", {29'h0, tx_last_slot}, {29'h0, tx_order[k]});
      chk("tx bytes", u_ptp_far_end_model.tx_bytes, 32'd64);
      chk("tx byte 14", {24'h0, u_ptp_far_end_model.tx_b14}, (k < 2) ? 32'(tx_order[k]) : 0);
    end
    chk("waiting cleared", {24'h0, tx_waiting}, 32'h0);
    for (int k = 0; k < 3; k++)
    begin
      cfg_read(17'h110FC + 17'(tx_order[k]) * 17'h100);
      chk("tx stamp", {31'h0, (k == 0) ? (d - ts < 32'h100) : (d - prev >= 32'hA00)}, 32'h1);
      prev = d;
    end
    // Receive frames, one oversized, wrapping past slot 15
    for (int f = 0; f < 17; f++)
    begin
      len = (f == 3) ? 260 : 20 + ($urandom % 60);
      base = $urandom;
      ts = rtc_ns_wrap;
      u_ptp_far_end_model.send_frame(len, base);
      wait_done(1'b0);
      chk("rx slot", {28'h0, rx_last_slot}, f % 16);
      a = 17'h10000 + 17'((f % 16) * 256);
      cfg_read(a);
      chk("rx word0", d, exp_word(base, 0));
      cfg_read(a + 17'hFC);
      chk("rx stamp", {31'h0, d - ts < 32'h100}, 32'h1);
      if (len > 252)
      begin
        cfg_read(a + 17'hF8);
        chk("rx last kept", d, exp_word(base, 248));
      end
    end
    // Receive memory refuses writes
    cfg_read(17'h10000);
    ts = d;
    cfg_write(17'h10000, ~ts);
    chk("rx write err", {31'h0, err_seen}, 32'h1);
    cfg_read(17'h10000);
    chk("rx unchanged", d, ts);
    // Second reset restarts counter and slot sequence
    do_reset();
    #1;
    chk("rtc restart", {31'h0, rtc_ns_wrap < 32'h100}, 32'h1);
    u_ptp_far_end_model.send_frame(30, 8'h5A);
    wait_done(1'b0);
    chk("rx slot after reset", {28'h0, rx_last_slot}, 32'h0);
    end_sim();
  end
endmodule : ptp_timestamp_packet_buffers_tb_top

bind ptp_timestamp_packet_buffers ptp_buf_assertions u_ptp_buf_assertions (.clk(clk),
  .rst_b(rst_b), .rtc_increment(rtc_increment), .rtc_ns_wrap(rtc_ns_wrap),
  .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rvalid(cfg_rvalid),
  .cfg_err(cfg_err), .tx_waiting(tx_waiting), .tx_last_slot(tx_last_slot),
  .tx_done(tx_done), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
  .tx_ready(tx_ready), .rx_last_slot(rx_last_slot), .rx_done(rx_done));
